// ===== logic/burst_counter.sv
/*
  burst address counter of one ram port: clear, load, hold, increment.
  assumes inputs are already synchronous to pclk.
*/
`timescale 1ns/10ps
module burst_counter #(
  parameter int ADDR_W = 17
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              clear_n,
  input  wire logic              strobe_n,
  input  wire logic              advance_n,
  input  wire logic [ADDR_W-1:0] ext_addr,
  output logic      [ADDR_W-1:0] access_addr,
  output logic      [ADDR_W-1:0] count
);
  logic [ADDR_W-1:0] count_q;  // counter state
  logic [ADDR_W-1:0] count_d;  // next counter state

  // priority: clear, load, increment, hold; chip selects play no part
  always_comb begin
    if (!clear_n) begin
      access_addr = '0;
    end else if (!strobe_n) begin
      access_addr = ext_addr;
    end else if (!advance_n) begin
      access_addr = count_q + ADDR_W'(1);
    end else begin
      access_addr = count_q;
    end
    count_d = access_addr;
  end

  // counter register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (ce) begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
endmodule

// ===== logic/dpram_pkg.sv
/*
  constants shared by the dual-port ram model, its port interface and the
  port controller: widths, control register map, field positions, timing.
  assumes a single 100 MHz clock (pclk) for both ports and the controller.
*/
package dpram_pkg;

  // array shape
  localparam int ADDR_WIDTH = 17;              // 128k words
  localparam int DATA_WIDTH = 9;               // x9 organisation
  localparam int NUM_PORTS  = 2;               // left and right port

  // controller register offsets (byte addresses, one word each)
  localparam logic [7:0] CTRL_OFS   = 8'h00;   // command and mode
  localparam logic [7:0] ADDR_OFS   = 8'h04;   // access address
  localparam logic [7:0] WDATA_OFS  = 8'h08;   // data to write
  localparam logic [7:0] RDATA_OFS  = 8'h0c;   // data read back
  localparam logic [7:0] STATUS_OFS = 8'h10;   // busy and done

  // control field positions
  localparam int CTRL_START_BIT = 0;           // write 1 to launch, self clearing
  localparam int CTRL_WRITE_BIT = 1;           // 1 write, 0 read
  localparam int CTRL_COUNT_BIT = 2;           // 1 use burst counter, 0 load address
  localparam int CTRL_CLEAR_BIT = 3;           // 1 clear the burst counter only
  localparam int CTRL_PIPE_BIT  = 4;           // output mode pin level
  localparam int CTRL_WIDTH     = 5;           // stored control bits
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;

  // status field positions
  localparam int STATUS_BUSY_BIT = 0;          // operation in flight
  localparam int STATUS_DONE_BIT = 1;          // sticky, write 1 to clear

  // timing
  localparam int CLK_PERIOD_NS          = 10;  // pclk period
  localparam int WRITE_TO_READ_DELAY_NS = 30;  // write clock to other-port read data
  localparam int PORT_CLOCK_SPACING_NS  = 9;   // clock to clock set-up between ports
  localparam int W2R_CYCLES = (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // controller sequencer states, gray along idle-drive-wait
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRIVE = 2'b01,
    ST_WAIT  = 2'b11
  } host_state_t;

  // control pins driven by the controller, all from flops
  typedef struct packed {
    logic cs_low_n;   // chip select, active low
    logic cs_high;    // chip select, active high
    logic rw;         // 1 read, 0 write
    logic ads_n;      // address strobe
    logic adv_n;      // counter advance
    logic clr_n;      // counter clear
    logic oe_n;       // output enable
    logic dq_oe;      // controller drives the data pins
  } pins_t;

  localparam pins_t PINS_IDLE = '{cs_low_n: 1'b1, cs_high: 1'b0, rw: 1'b1, ads_n: 1'b1,
                                  adv_n: 1'b1, clr_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0};

endpackage

// ===== logic/dual_port_ram.sv
/*
  synchronous dual-port static ram: shared array, two identical ports, each
  with registered inputs, a burst counter and flow-through or pipelined output.
  assumes every port pin is driven by logic on pclk; output enable is taken
  as it stands, without a clock.
*/
`timescale 1ns/10ps
module dual_port_ram
  import dpram_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DATA_W = DATA_WIDTH,
  parameter int PORTS  = NUM_PORTS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  ram_port_if.dev   ports [PORTS]
);
  localparam int DEPTH = 2 ** ADDR_W;  // words in the array

  // shared storage
  logic [DATA_W-1:0] mem_q [DEPTH];

  // per-port signals gathered for the shared write process
  logic [ADDR_W-1:0] acc_addr [PORTS];  // internal access address
  logic              wr_en    [PORTS];  // write this edge
  logic [DATA_W-1:0] wr_data  [PORTS];  // data sampled from the pins

  // one port's select: low-active select low and high-active select high
  function automatic logic port_selected(input logic cs_low_n, input logic cs_high);
    return !cs_low_n && cs_high;
  endfunction

  // identical logic for every port; each port has its own counter and controls
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    logic              sel;            // port selected at this edge
    logic [DATA_W-1:0] rd_flow_q;      // flow-through output register
    logic [DATA_W-1:0] rd_flow_d;
    logic              en_flow_q;      // flow-through read in progress
    logic              en_flow_d;
    logic [DATA_W-1:0] rd_pipe_q;      // pipelined output register
    logic [DATA_W-1:0] rd_pipe_d;
    logic              en_pipe_q;      // pipelined read in progress
    logic              en_pipe_d;
    logic              pipe_mode;      // output mode pin level
    logic              drive_state;    // read state chosen by mode

    // select sampled at the same edge as address and data
    assign sel = port_selected(ports[g].chip_select_low_active_n,
                               ports[g].chip_select_high_active);

    // burst counter runs whatever the selects say
    burst_counter #(
      .ADDR_W (ADDR_W)
    ) u_counter (
      .pclk        (pclk),
      .presetn     (presetn),
      .ce          (ce),
      .clear_n     (ports[g].counter_clear_n),
      .strobe_n    (ports[g].address_strobe_n),
      .advance_n   (ports[g].counter_advance_n),
      .ext_addr    (ports[g].address),
      .access_addr (acc_addr[g]),
      .count       ()
    );

    // write request for the shared array process
    always_comb begin
      wr_en[g]   = sel && !ports[g].read_write;
      wr_data[g] = ports[g].dq;
    end

    // next values of the output stages
    always_comb begin
      // flow-through stage takes the word at the edge the address is sampled
      rd_flow_d = mem_q[acc_addr[g]];
      // read state: selected read, else deselected or writing means float
      en_flow_d = sel && ports[g].read_write;
      // pipelined stage repeats the flow-through stage one edge later
      rd_pipe_d = rd_flow_q;
      en_pipe_d = en_flow_q;
    end

    // output stage registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rd_flow_q <= '0;
        en_flow_q <= 1'b0;
        rd_pipe_q <= '0;
        en_pipe_q <= 1'b0;
      end else if (ce) begin
        rd_flow_q <= rd_flow_d;
        en_flow_q <= en_flow_d;
        rd_pipe_q <= rd_pipe_d;
        en_pipe_q <= en_pipe_d;
      end
    end

    // mode pin low bypasses the pipeline register
    always_comb begin
      pipe_mode = ports[g].output_mode_select;
      if (pipe_mode) begin
        drive_state = en_pipe_q;
      end else begin
        drive_state = en_flow_q;
      end
    end

    // data from the chosen stage; enable gated by output enable without a clock
    assign ports[g].dev_dq_o  = pipe_mode ? rd_pipe_q : rd_flow_q;
    assign ports[g].dev_dq_oe = drive_state && !ports[g].output_enable_n;
  end

  // shared array writes; a word written here is read by the other port from
  // the next edge on, well inside the write-to-read delay
  always_ff @(posedge pclk) begin
    if (ce) begin
      // higher port index wins when both write the same word at once
      for (int p = 0; p < PORTS; p++) begin
        if (wr_en[p]) begin
          mem_q[acc_addr[p]] <= wr_data[p];
        end
      end
    end
  end

  // note on turnaround: a no-operation cycle between read and write may leave
  // the addressed word unreliable on real silicon; this model keeps it intact,
  // the controller does not rewrite it afterwards
endmodule

// ===== logic/ram_port_host.sv
/*
  controller for one ram port: software writes address, data and a command
  over apb; the sequencer drives the port pins and collects read data.
  assumes the ram samples its pins on the same pclk; apb has zero wait states.
*/
`timescale 1ns/10ps
module ram_port_host
  import dpram_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DATA_W = DATA_WIDTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  ram_port_if.host         port
);
  localparam logic [2:0] W2R_WAIT = 3'(W2R_CYCLES);  // write settle cycles

  host_state_t           state_q, state_d;   // sequencer
  logic [2:0]            wait_q, wait_d;     // cycles left in wait
  logic [CTRL_WIDTH-1:0] ctrl_q, ctrl_d;     // stored command and mode
  logic [ADDR_W-1:0]     addr_q, addr_d;     // access address
  logic [DATA_W-1:0]     wdata_q, wdata_d;   // data to write
  logic [DATA_W-1:0]     rdata_q, rdata_d;   // last word read
  logic                  done_q, done_d;     // sticky completion
  pins_t                 pins_q, pins_d;     // registered port pins
  logic [31:0]           prdata_q, prdata_d; // read data latched in setup
  logic                  wr_acc;             // apb write access phase
  logic                  start;              // launch request
  logic                  mapped;             // address decodes

  assign wr_acc = psel && penable && pwrite && ce;
  assign start  = wr_acc && (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT];
  assign mapped = (paddr == CTRL_OFS) || (paddr == ADDR_OFS) || (paddr == WDATA_OFS) ||
                  (paddr == RDATA_OFS) || (paddr == STATUS_OFS);

  // apb answer: zero wait states, error on unmapped offsets
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // next values of registers and sequencer
  always_comb begin
    state_d  = state_q;
    wait_d   = wait_q;
    ctrl_d   = ctrl_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    done_d   = done_q;
    pins_d   = pins_q;
    prdata_d = prdata_q;
    // read mux latched in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        CTRL_OFS:   prdata_d = 32'(ctrl_q);
        ADDR_OFS:   prdata_d = 32'(addr_q);
        WDATA_OFS:  prdata_d = 32'(wdata_q);
        RDATA_OFS:  prdata_d = 32'(rdata_q);
        STATUS_OFS: prdata_d = 32'({done_q, state_q != ST_IDLE});
        default:    prdata_d = 32'h0000_0000;
      endcase
    end
    // register writes, ignored while busy except status
    if (wr_acc && state_q == ST_IDLE) begin
      if (paddr == CTRL_OFS) ctrl_d = pwdata[CTRL_WIDTH-1:0];
      if (paddr == ADDR_OFS) addr_d = pwdata[ADDR_W-1:0];
      if (paddr == WDATA_OFS) wdata_d = pwdata[DATA_W-1:0];
    end
    ctrl_d[CTRL_START_BIT] = 1'b0;  // start bit is a strobe, never stored
    if (wr_acc && paddr == STATUS_OFS && pwdata[STATUS_DONE_BIT]) done_d = 1'b0;
    // sequencer
    unique case (state_q)
      ST_IDLE: begin
        if (start && state_q == ST_IDLE) begin
          pins_d = PINS_IDLE;
          done_d = 1'b0;
          if (pwdata[CTRL_CLEAR_BIT]) begin
            pins_d.clr_n = 1'b0;                           // counter clear, no select
            wait_d = 3'h1;
          end else begin
            pins_d.cs_low_n = 1'b0;
            pins_d.cs_high  = 1'b1;
            pins_d.ads_n    = pwdata[CTRL_COUNT_BIT];
            pins_d.adv_n    = !pwdata[CTRL_COUNT_BIT];
            pins_d.rw       = !pwdata[CTRL_WRITE_BIT];
            pins_d.dq_oe    = pwdata[CTRL_WRITE_BIT];
            pins_d.oe_n     = pwdata[CTRL_WRITE_BIT];
            wait_d = pwdata[CTRL_WRITE_BIT] ? W2R_WAIT : 3'(1 + 32'(pwdata[CTRL_PIPE_BIT]));
          end
          state_d = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        // pins were sampled at this edge; back to idle, keep output enable
        pins_d      = PINS_IDLE;
        pins_d.oe_n = pins_q.oe_n;
        state_d     = ST_WAIT;
      end
      ST_WAIT: begin
        wait_d = wait_q - 3'h1;
        if (wait_q == 3'h1) begin
          if (!ctrl_q[CTRL_WRITE_BIT] && !ctrl_q[CTRL_CLEAR_BIT]) rdata_d = port.dq;
          pins_d.oe_n = 1'b1;
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
      end
      // unused code: fall back to idle
      default: state_d = ST_IDLE;
    endcase
  end

  // registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_IDLE;
      wait_q   <= 3'h0;
      ctrl_q   <= CTRL_RESET;
      addr_q   <= '0;
      wdata_q  <= '0;
      rdata_q  <= '0;
      done_q   <= 1'b0;
      pins_q   <= PINS_IDLE;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      state_q  <= state_d;
      wait_q   <= wait_d;
      ctrl_q   <= ctrl_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      done_q   <= done_d;
      pins_q   <= pins_d;
      prdata_q <= prdata_d;
    end
  end

  // port pins straight from flops
  assign port.output_mode_select       = ctrl_q[CTRL_PIPE_BIT];
  assign port.chip_select_low_active_n = pins_q.cs_low_n;
  assign port.chip_select_high_active  = pins_q.cs_high;
  assign port.read_write               = pins_q.rw;
  assign port.address                  = addr_q;
  assign port.address_strobe_n         = pins_q.ads_n;
  assign port.counter_advance_n        = pins_q.adv_n;
  assign port.counter_clear_n          = pins_q.clr_n;
  assign port.output_enable_n          = pins_q.oe_n;
  assign port.host_dq_o                = wdata_q;
  assign port.host_dq_oe               = pins_q.dq_oe;
endmodule

// ===== logic/ram_port_if.sv
/*
  pin bundle of one ram port: control pins from the controller, the shared
  data pins resolved from both enables.
  assumes both ends run on the same pclk and never drive data together.
*/
`timescale 1ns/10ps
interface ram_port_if #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 9
);
  logic              output_mode_select;        // low flow-through, high pipelined
  logic              chip_select_low_active_n;  // select, active low
  logic              chip_select_high_active;   // select, active high
  logic              read_write;                // high read, low write
  logic [ADDR_W-1:0] address;                   // external address
  logic              address_strobe_n;          // low loads the address
  logic              counter_advance_n;         // low increments the counter
  logic              counter_clear_n;           // low clears the counter
  logic              output_enable_n;           // asynchronous output enable
  logic [DATA_W-1:0] host_dq_o;                 // controller data out
  logic              host_dq_oe;                // controller drives data
  logic [DATA_W-1:0] dev_dq_o;                  // ram data out
  logic              dev_dq_oe;                 // ram drives data
  logic [DATA_W-1:0] dq;                        // resolved data pins

  // wire level of the data pins, zero when nobody drives
  assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : '0);

  // ram end
  modport dev (
    input  output_mode_select, chip_select_low_active_n, chip_select_high_active,
    input  read_write, address, address_strobe_n, counter_advance_n,
    input  counter_clear_n, output_enable_n, dq,
    output dev_dq_o, dev_dq_oe
  );

  // controller end
  modport host (
    output output_mode_select, chip_select_low_active_n, chip_select_high_active,
    output read_write, address, address_strobe_n, counter_advance_n,
    output counter_clear_n, output_enable_n, host_dq_o, host_dq_oe,
    input  dq, dev_dq_oe
  );
endinterface

// ===== verification/sync_dual_port_ram_port_assertions.sv
/*
  concurrent checks on the pins of port 0 between controller and ram.
  assumes the bench instantiates it beside the port interface, on pclk.
*/
`timescale 1ns/10ps
module sync_dual_port_ram_port_assertions
  import dpram_pkg::*;
#(
  parameter int DATA_W = DATA_WIDTH
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              output_mode_select,
  input wire logic              chip_select_low_active_n,
  input wire logic              chip_select_high_active,
  input wire logic              read_write,
  input wire logic              output_enable_n,
  input wire logic [DATA_W-1:0] host_dq_o,
  input wire logic              host_dq_oe,
  input wire logic [DATA_W-1:0] dev_dq_o,
  input wire logic              dev_dq_oe,
  input wire logic [DATA_W-1:0] dq
);
  logic sel;  // both chip selects active

  // port counts as selected only with both selects active
  assign sel = !chip_select_low_active_n && chip_select_high_active;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // read sampled in flow-through mode
  sequence s_flow_read;
    sel && read_write && !output_mode_select;
  endsequence
  // read sampled in pipelined mode, mode kept next cycle
  sequence s_pipe_read;
    (sel && read_write && output_mode_select) ##1 output_mode_select;
  endsequence
  // deselect sampled in pipelined mode, mode kept next cycle
  sequence s_pipe_desel;
    (!sel && output_mode_select) ##1 output_mode_select;
  endsequence

  chk_oe_gates_drive: assert property (
    dev_dq_oe |-> !output_enable_n) else $error("ram drives data with output enable off");
  chk_flow_read_drive: assert property (
    s_flow_read ##1 (!output_enable_n && !output_mode_select) |-> dev_dq_oe)
    else $error("flow-through read not driven one cycle later");
  chk_flow_deselect: assert property (
    (!sel && !output_mode_select) ##1 !output_mode_select |-> !dev_dq_oe)
    else $error("flow-through output not floated after deselect");
  chk_pipe_read_late: assert property (
    s_pipe_read ##1 (output_mode_select && !output_enable_n) |-> dev_dq_oe && dq == dev_dq_o)
    else $error("pipelined read not driven two cycles later");
  chk_pipe_not_early: assert property (
    (!sel && output_mode_select) ##1 (sel && read_write && output_mode_select) |=> !dev_dq_oe)
    else $error("pipelined read driven one cycle early");
  chk_pipe_deselect: assert property (
    s_pipe_desel ##1 output_mode_select |-> !dev_dq_oe)
    else $error("pipelined output not floated after deselect");
  chk_write_no_drive: assert property (
    (sel && !read_write && !output_mode_select) ##1 !output_mode_select |-> !dev_dq_oe)
    else $error("ram drives data after a write");
  chk_write_data_on: assert property (
    (sel && !read_write) |-> host_dq_oe && output_enable_n && dq == host_dq_o)
    else $error("write cycle without controller data");
  chk_one_driver: assert property (
    !(host_dq_oe && dev_dq_oe)) else $error("both ends drive the data pins");
  chk_read_oe_on: assert property (
    (sel && read_write) |-> !output_enable_n && !$past(host_dq_oe, 1))
    else $error("read cycle without output enable");
endmodule

// ===== verification/sync_dual_port_ram_port_test.sv
/*
  self-checking bench: two apb controllers drive the two ports of the ram.
  assumes one 100 MHz pclk for everything and an interface array of two ports.
*/
`timescale 1ns/10ps
module sync_dual_port_ram_port_test
  import dpram_pkg::*;
;
  typedef struct packed {
    logic       port;  // which controller
    logic [4:0] ctrl;  // command word
    logic [16:0] addr; // access address
    logic [8:0] data;  // write data
    logic [8:0] exp;   // expected read data
  } row_t;

  logic        pclk;           // common clock
  logic        presetn;        // async reset, active low
  logic        ce;             // clock enable, high except during the ce_freeze check
  logic [7:0]  paddr   [2];    // apb address per controller
  logic        psel    [2];    // apb select
  logic        penable [2];    // apb enable
  logic        pwrite  [2];    // apb direction
  logic [31:0] pwdata  [2];    // apb write data
  logic [31:0] prdata  [2];    // apb read data
  logic        pready  [2];    // apb ready
  logic        pslverr [2];    // apb error
  int          n_errors;       // mismatches
  int          checked;        // comparisons
  // ctrl: 03 write, 01 read, +10 pipelined, 07/05 counter write/read, 09 clear
  row_t rows [12] = '{'{1'b0, 5'h03, 17'h00010, 9'h1a5, 9'h000}, '{1'b1, 5'h01, 17'h00010, 9'h000, 9'h1a5},
                      '{1'b1, 5'h13, 17'h1ffff, 9'h05a, 9'h000}, '{1'b0, 5'h11, 17'h1ffff, 9'h000, 9'h05a},
                      '{1'b0, 5'h09, 17'h00000, 9'h000, 9'h000}, '{1'b0, 5'h07, 17'h00000, 9'h011, 9'h000},
                      '{1'b1, 5'h01, 17'h00001, 9'h000, 9'h011}, '{1'b0, 5'h17, 17'h00000, 9'h022, 9'h000},
                      '{1'b1, 5'h05, 17'h00000, 9'h000, 9'h022}, '{1'b1, 5'h03, 17'h00003, 9'h0ff, 9'h000},
                      '{1'b0, 5'h15, 17'h00000, 9'h000, 9'h0ff}, '{1'b1, 5'h09, 17'h00000, 9'h000, 9'h000}};

  ram_port_if #(.ADDR_W(ADDR_WIDTH), .DATA_W(DATA_WIDTH)) rp [2] ();

  dual_port_ram i_dual_port_ram (.pclk(pclk), .presetn(presetn), .ce(ce), .ports(rp));

  // one controller per port
  for (genvar i = 0; i < 2; i++) begin : g_host
    ram_port_host i_ram_port_host (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr[i]), .psel(psel[i]),
      .penable(penable[i]), .pwrite(pwrite[i]), .pwdata(pwdata[i]), .prdata(prdata[i]), .pready(pready[i]),
      .pslverr(pslverr[i]), .port(rp[i]));
  end

  sync_dual_port_ram_port_assertions #(.DATA_W(DATA_WIDTH)) i_sync_dual_port_ram_port_assertions (
    .pclk(pclk), .presetn(presetn), .output_mode_select(rp[0].output_mode_select),
    .chip_select_low_active_n(rp[0].chip_select_low_active_n), .chip_select_high_active(rp[0].chip_select_high_active),
    .read_write(rp[0].read_write), .output_enable_n(rp[0].output_enable_n), .host_dq_o(rp[0].host_dq_o),
    .host_dq_oe(rp[0].host_dq_oe), .dev_dq_o(rp[0].dev_dq_o), .dev_dq_oe(rp[0].dev_dq_oe), .dq(rp[0].dq));

  // clock generator
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic conclude();
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one comparison, mismatch reported at once
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer: setup, access held until pready
  task automatic apb(input int p, input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel[p] <= 1'b1;
    penable[p] <= 1'b0;
    paddr[p] <= a;
    pwrite[p] <= w;
    pwdata[p] <= wd;
    @(posedge pclk);
    penable[p] <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready[p] !== 1'b1 && n < 100);
    check("pready", {31'h0, pready[p]}, 32'h1);
    rd = prdata[p];
    err = pslverr[p];
    psel[p] <= 1'b0;
    penable[p] <= 1'b0;
  endtask

  // register write
  task automatic wr(input int p, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(p, a, 1'b1, d, rd, e);
  endtask

  // register read
  task automatic rd_reg(input int p, input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(p, a, 1'b0, 32'h0, d, e);
  endtask

  // wait for the done flag, then fetch the read data
  task automatic finish_op(input int p, output logic [31:0] d);
    int n;
    n = 0;
    do begin
      rd_reg(p, STATUS_OFS, d);
      n++;
    end while (d[STATUS_DONE_BIT] !== 1'b1 && n < 50);
    check("done", {31'h0, d[STATUS_DONE_BIT]}, 32'h1);
    rd_reg(p, RDATA_OFS, d);
  endtask

  // program address, data and command of one row, run it
  task automatic run(input row_t r, output logic [31:0] d);
    wr(r.port, ADDR_OFS, {15'h0, r.addr});
    wr(r.port, WDATA_OFS, {23'h0, r.data});
    wr(r.port, CTRL_OFS, {27'h0, r.ctrl});
    finish_op(r.port, d);
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  // main sequence: table, then awkward cases, then reset
  initial begin
    logic [31:0] d;
    logic        e;
    n_errors = 0;
    checked = 0;
    ce = 1'b1;
    presetn = 1'b0;
    for (int i = 0; i < 2; i++) begin
      paddr[i] = 8'h00;
      psel[i] = 1'b0;
      penable[i] = 1'b0;
      pwrite[i] = 1'b0;
      pwdata[i] = 32'h0;
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i], d);
      if (!rows[i].ctrl[1] && !rows[i].ctrl[3]) check("rdata", d, {23'h0, rows[i].exp});
    end
    run('{1'b1, 5'h05, 17'h0, 9'h0, 9'h0}, d);
    check("rdata_after_clear", d, 32'h011);
    // writes to the data register are ignored while busy
    wr(0, ADDR_OFS, 32'h20);
    wr(0, WDATA_OFS, 32'h0c3);
    wr(0, CTRL_OFS, 32'h03);
    wr(0, WDATA_OFS, 32'h111);
    rd_reg(0, WDATA_OFS, d);
    check("wdata_busy", d, 32'h0c3);
    finish_op(0, d);
    run('{1'b1, 5'h11, 17'h20, 9'h0, 9'h0}, d);
    check("cross_read", d, 32'h0c3);
    // flow-through read on port 0 of the word it wrote after a turnaround
    run('{1'b0, 5'h01, 17'h20, 9'h0, 9'h0}, d);
    check("own_read", d, 32'h0c3);
    rd_reg(0, CTRL_OFS, d);
    check("ctrl_start_clear", d, 32'h0);
    // address register keeps only its low bits
    wr(1, ADDR_OFS, 32'hffffffff);
    rd_reg(1, ADDR_OFS, d);
    check("addr_width", d, 32'h0001ffff);
    // clock enable low: register write is lost
    ce <= 1'b0;
    wr(1, ADDR_OFS, 32'h5);
    ce <= 1'b1;
    rd_reg(1, ADDR_OFS, d);
    check("ce_freeze", d, 32'h0001ffff);
    // unmapped address: error response, zero data
    apb(0, 8'h14, 1'b0, 32'h0, d, e);
    check("unmapped_data", d, 32'h0);
    check("unmapped_err", {31'h0, e}, 32'h1);
    // done flag cleared by writing one to it
    wr(0, STATUS_OFS, 32'h2);
    rd_reg(0, STATUS_OFS, d);
    check("done_clear", d, 32'h0);
    // reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    check("dev_oe_reset", {31'h0, rp[0].dev_dq_oe}, 32'h0);
    check("cs_idle_reset", {31'h0, rp[1].chip_select_low_active_n}, 32'h1);
    presetn <= 1'b1;
    rd_reg(0, CTRL_OFS, d);
    check("ctrl_reset", d, {27'h0, CTRL_RESET});
    rd_reg(1, STATUS_OFS, d);
    check("status_reset", d, 32'h0);
    conclude();
  end
endmodule
